/* File: irpe_pkg.sv */
/*
 Package for the interrupt request and priority enable unit: register indices,
 field positions, reset values, source numbering and state codes.
 Assumes an Avalon-MM slave with 32-bit data and word addresses.
*/
package irpe_pkg;
  // Register indices; printed offsets are not multiples of four, byte address is four times these
  localparam logic [11:0] IDX_GROUP0_REQUEST = 12'hFC0;
  localparam logic [11:0] IDX_GROUP0_ENABLE_HIGH = 12'hFC1;
  localparam logic [11:0] IDX_GROUP0_ENABLE_LOW = 12'hFC2;
  localparam logic [11:0] IDX_PORT_A_REQUEST = 12'hFC3;
  localparam logic [11:0] IDX_PORT_A_ENABLE_HIGH = 12'hFC4;
  localparam logic [11:0] IDX_PORT_A_ENABLE_LOW = 12'hFC5;
  localparam logic [11:0] IDX_PORT_C_REQUEST = 12'hFC6;
  localparam logic [11:0] IDX_PORT_C_ENABLE_HIGH = 12'hFC7;
  localparam logic [11:0] IDX_PORT_C_ENABLE_LOW = 12'hFC8;
  localparam logic [11:0] IDX_SHARED_SOURCE_SELECT = 12'hFCE;
  localparam logic [11:0] IDX_IRQ_CONTROL = 12'hFCF;
  localparam logic [11:0] IDX_EVENT_STATUS = 12'hFD0;
  localparam logic [11:0] IDX_EVENT_MASK = 12'hFD1;
  localparam logic [11:0] IDX_ACTIVE_VECTOR = 12'hFD2;

  // Writable bit masks per register
  localparam logic [7:0] MASK_GROUP0 = 8'h79;
  localparam logic [7:0] MASK_PORT_A = 8'hFF;
  localparam logic [7:0] MASK_PORT_C = 8'h0F;
  localparam logic [7:0] MASK_SHARED = 8'hC0;
  localparam logic [7:0] MASK_EVENT = 8'h07;

  // Field positions
  localparam int GIE_BIT = 7;
  localparam int SHARED_PIN7_BIT = 7;
  localparam int SHARED_PIN6_BIT = 6;
  localparam int EVT_REQ_BIT = 0;
  localparam int EVT_ACK_BIT = 1;
  localparam int EVT_SWSET_BIT = 2;

  // Reset value of every register except the active vector, which reads NO_VECTOR
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // Flattened source numbering: group0 0..7, port A 8..15, port C 16..19
  localparam int NUM_SRC = 24;
  localparam logic [4:0] NO_VECTOR = 5'h1F;

  // Bus answer latency: one wait cycle on every access
  typedef enum logic [0:0]
  {
    IRPE_IDLE = 1'b0,
    IRPE_DONE = 1'b1
  } irpe_bus_e;
endpackage

/* File: irpe_top.sv */
/*
 Interrupt request, priority enable and core handoff unit.
 Register bus: every access takes two cycles; read data is captured in the wait
 cycle, so it already stands on the edge where waitrequest is sampled low.
 Status reads clear only the bits they reported, so no event is lost.
 Assumes request inputs are synchronous single-cycle or level events from logic on i_clk,
 and that the core acknowledges the vector it is shown with a one-cycle pulse.
*/
// Register access over Avalon-MM was decided locally.
`timescale 1ns/100ps
module irpe_top
  import irpe_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Avalon-MM slave
  input wire logic [11:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Request sources
  input wire logic [7:0] i_group0_src,
  input wire logic [5:0] i_port_a_src,
  input wire logic i_pin7_src,
  input wire logic i_low_voltage_detector,
  input wire logic i_pin6_src,
  input wire logic i_comparator,
  input wire logic [3:0] i_port_c_src,
  // Core instructions
  input wire logic i_enable_interrupts_instr,
  input wire logic i_interrupt_return_instr,
  input wire logic i_disable_interrupts_instr,
  // Core handoff
  output logic o_irq_req,
  output logic [4:0] o_irq_vector,
  output logic [1:0] o_irq_level,
  input wire logic i_irq_ack,
  // Event interrupt
  output logic o_event_irq
);
  logic [7:0] req_r [3];
  logic [7:0] req_nxt [3];
  logic [7:0] enh_r [3];
  logic [7:0] enh_nxt [3];
  logic [7:0] enl_r [3];
  logic [7:0] enl_nxt [3];
  logic [7:0] mask_w [3];
  logic [7:0] src_w [3];
  logic [7:0] shared_r, shared_nxt;
  logic gie_r, gie_nxt;
  logic [7:0] evt_r, evt_nxt;
  logic [7:0] emask_r, emask_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [4:0] vec_r, vec_nxt;
  logic [1:0] lvl_r, lvl_nxt;
  logic req_out_r, req_out_nxt;
  irpe_bus_e bus_r, bus_nxt;
  logic acc, wr_go, rd_go, rd_cap, sw_set;
  logic [7:0] wbyte;
  logic [4:0] best_v;
  logic [1:0] best_l;

  assign mask_w[0] = MASK_GROUP0;
  assign mask_w[1] = MASK_PORT_A;
  assign mask_w[2] = MASK_PORT_C;

  // Shared sources are chosen before they reach the port A request bits
  always_comb
  begin
    src_w[0] = i_group0_src & MASK_GROUP0;
    src_w[1][5:0] = i_port_a_src;
    src_w[1][SHARED_PIN6_BIT] = shared_r[SHARED_PIN6_BIT] ? i_comparator : i_pin6_src;
    src_w[1][SHARED_PIN7_BIT] = shared_r[SHARED_PIN7_BIT] ? i_low_voltage_detector : i_pin7_src;
    src_w[2] = {4'h0, i_port_c_src};
  end

  // One wait cycle, then the access completes in the second cycle
  assign acc = i_avs_read | i_avs_write;
  assign wr_go = i_avs_write & (bus_r == IRPE_DONE);
  assign rd_go = i_avs_read & (bus_r == IRPE_DONE);
  // Read data is captured in the wait cycle so it stands when waitrequest drops
  assign rd_cap = i_avs_read & (bus_r == IRPE_IDLE);
  assign wbyte = i_avs_byteenable[0] ? i_avs_writedata[7:0] : 8'h00;
  assign o_avs_waitrequest = acc & (bus_r == IRPE_IDLE);
  assign o_avs_readdata = rdata_r;

  // Bus phase; the wait is fixed, so a master never sees a longer stall
  always_comb
  begin
    case (bus_r)
      IRPE_IDLE: bus_nxt = acc ? IRPE_DONE : IRPE_IDLE;
      IRPE_DONE: bus_nxt = IRPE_IDLE;
      default: bus_nxt = IRPE_IDLE;
    endcase
  end

  // Bus phase register
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      bus_r <= IRPE_IDLE;
    else
      bus_r <= bus_nxt;
  end

  // Read mux; the snapshot taken here is also what a status read clears
  always_comb
  begin
    rdata_nxt = rdata_r;
    if (rd_cap)
    begin
      rdata_nxt = 32'h0000_0000;
      case (i_avs_address)
        IDX_GROUP0_REQUEST: rdata_nxt[7:0] = req_r[0];
        IDX_GROUP0_ENABLE_HIGH: rdata_nxt[7:0] = enh_r[0];
        IDX_GROUP0_ENABLE_LOW: rdata_nxt[7:0] = enl_r[0];
        IDX_PORT_A_REQUEST: rdata_nxt[7:0] = req_r[1];
        IDX_PORT_A_ENABLE_HIGH: rdata_nxt[7:0] = enh_r[1];
        IDX_PORT_A_ENABLE_LOW: rdata_nxt[7:0] = enl_r[1];
        IDX_PORT_C_REQUEST: rdata_nxt[7:0] = req_r[2];
        IDX_PORT_C_ENABLE_HIGH: rdata_nxt[7:0] = enh_r[2];
        IDX_PORT_C_ENABLE_LOW: rdata_nxt[7:0] = enl_r[2];
        IDX_SHARED_SOURCE_SELECT: rdata_nxt[7:0] = shared_r;
        IDX_IRQ_CONTROL: rdata_nxt[GIE_BIT] = gie_r;
        IDX_EVENT_STATUS: rdata_nxt[7:0] = evt_r;
        IDX_EVENT_MASK: rdata_nxt[7:0] = emask_r;
        IDX_ACTIVE_VECTOR: rdata_nxt[7:0] = {req_out_r, lvl_r, vec_r};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Read data register
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      rdata_r <= 32'h0000_0000;
    else
      rdata_r <= rdata_nxt;
  end

  // Priority search: higher level wins, lower source number wins a tie
  always_comb
  begin
    logic [1:0] code;
    code = 2'b00;
    best_v = NO_VECTOR;
    best_l = 2'b00;
    for (int g = 0; g < 3; g++)
    begin
      for (int b = 0; b < 8; b++)
      begin
        code = {enh_r[g][b], enl_r[g][b]};
        if (req_r[g][b] && (code > best_l))
        begin
          best_l = code;
          best_v = 5'(g * 8 + b);
        end
      end
    end
  end

  // Request, enable and control state
  always_comb
  begin
    logic [7:0] ack_clr;
    ack_clr = 8'h00;
    sw_set = 1'b0;
    shared_nxt = shared_r;
    gie_nxt = gie_r;
    for (int g = 0; g < 3; g++)
    begin
      enh_nxt[g] = enh_r[g];
      enl_nxt[g] = enl_r[g];
      req_nxt[g] = req_r[g];
      ack_clr = (i_irq_ack && req_out_r && vec_r[4:3] == 2'(g)) ? (8'h01 << vec_r[2:0]) : 8'h00;
      // Acknowledge clears first so a same-cycle source event still sets
      req_nxt[g] = req_nxt[g] & ~ack_clr;
      if (wr_go && i_avs_address == IDX_GROUP0_REQUEST + 12'(3 * g))
      begin
        req_nxt[g] = wbyte & mask_w[g];
        sw_set = sw_set | ((wbyte & mask_w[g] & ~req_r[g]) != 8'h00);
      end
      if (wr_go && i_avs_address == IDX_GROUP0_ENABLE_HIGH + 12'(3 * g))
        enh_nxt[g] = wbyte & mask_w[g];
      if (wr_go && i_avs_address == IDX_GROUP0_ENABLE_LOW + 12'(3 * g))
        enl_nxt[g] = wbyte & mask_w[g];
      req_nxt[g] = req_nxt[g] | src_w[g];
    end
    if (wr_go && i_avs_address == IDX_SHARED_SOURCE_SELECT)
      shared_nxt = wbyte & MASK_SHARED;
    // Global enable: clears take effect, then sets win
    if (i_disable_interrupts_instr || (i_irq_ack && req_out_r))
      gie_nxt = 1'b0;
    if (wr_go && i_avs_address == IDX_IRQ_CONTROL)
      gie_nxt = wbyte[GIE_BIT];
    if (i_enable_interrupts_instr || i_interrupt_return_instr)
      gie_nxt = 1'b1;
  end

  // Handoff to the core is registered so vector and level stay aligned;
  // the acknowledged cycle forces a gap so the core never takes one vector twice
  always_comb
  begin
    req_out_nxt = gie_r && (best_l != 2'b00) && !(i_irq_ack && req_out_r);
    vec_nxt = req_out_nxt ? best_v : NO_VECTOR;
    lvl_nxt = req_out_nxt ? best_l : 2'b00;
  end

  // Handoff register; reset shows no vector
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      vec_r <= NO_VECTOR;
      lvl_r <= 2'b00;
      req_out_r <= 1'b0;
    end
    else
    begin
      vec_r <= vec_nxt;
      lvl_r <= lvl_nxt;
      req_out_r <= req_out_nxt;
    end
  end

  // Event status: a read clears only the bits its snapshot reported,
  // then this cycle's events are added so a same-cycle event always wins
  always_comb
  begin
    evt_nxt = evt_r;
    emask_nxt = emask_r;
    if (wr_go && i_avs_address == IDX_EVENT_MASK)
      emask_nxt = wbyte & MASK_EVENT;
    if (rd_go && i_avs_address == IDX_EVENT_STATUS)
      evt_nxt = evt_r & ~rdata_r[7:0];
    evt_nxt[EVT_REQ_BIT] = evt_nxt[EVT_REQ_BIT] | (src_w[0] != 8'h00) | (src_w[1] != 8'h00) | (src_w[2] != 8'h00);
    evt_nxt[EVT_ACK_BIT] = evt_nxt[EVT_ACK_BIT] | (i_irq_ack & req_out_r);
    evt_nxt[EVT_SWSET_BIT] = evt_nxt[EVT_SWSET_BIT] | sw_set;
  end

  // Event status and mask registers
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      evt_r <= RESET_BYTE;
      emask_r <= RESET_BYTE;
    end
    else
    begin
      evt_r <= evt_nxt;
      emask_r <= emask_nxt;
    end
  end

  // Register stage; synchronous reset
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      for (int g = 0; g < 3; g++)
      begin
        req_r[g] <= RESET_BYTE;
        enh_r[g] <= RESET_BYTE;
        enl_r[g] <= RESET_BYTE;
      end
      shared_r <= RESET_BYTE;
      gie_r <= 1'b0;
    end
    else
    begin
      for (int g = 0; g < 3; g++)
      begin
        req_r[g] <= req_nxt[g];
        enh_r[g] <= enh_nxt[g];
        enl_r[g] <= enl_nxt[g];
      end
      shared_r <= shared_nxt;
      gie_r <= gie_nxt;
    end
  end

  // Level interrupt while any unmasked event bit stands
  assign o_event_irq = (evt_r & emask_r) != 8'h00;
  assign o_irq_req = req_out_r;
  assign o_irq_vector = vec_r;
  assign o_irq_level = lvl_r;
endmodule

/* File: irpe_core_model.sv */
/*
 Core side model: acknowledges the shown vector after a chosen delay.
 Assumes the unit's registered handoff outputs on the same clock.
*/
`timescale 1ns/100ps
module irpe_core_model
(
  // Clock, reset, bench control
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_allow,
  input wire logic [1:0] i_delay,
  // Handoff
  input wire logic i_irq_req,
  input wire logic [4:0] i_irq_vector,
  output logic o_irq_ack,
  output logic [4:0] o_taken_vector
);
  logic [1:0] wait_r;
  // One ack per shown vector; the gap after it lets the request fall first
  always_ff @(posedge i_clk)
  begin
    o_irq_ack <= 1'b0;
    if (!i_reset_n || o_irq_ack || !i_irq_req || !i_allow)
      wait_r <= 2'h0;
    else if (wait_r == i_delay)
    begin
      o_irq_ack <= 1'b1;
      o_taken_vector <= i_irq_vector;
    end
    else
      wait_r <= wait_r + 2'h1;
  end
endmodule

/* File: irpe_monitor.sv */
/*
 Port checker for the interrupt unit.
 Assumes one clock domain and the bind below.
*/
`timescale 1ns/100ps
module irpe_monitor
  import irpe_pkg::*;
(
  // Watched ports
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic i_enable_interrupts_instr,
  input wire logic i_interrupt_return_instr,
  input wire logic i_disable_interrupts_instr,
  input wire logic o_irq_req,
  input wire logic [4:0] o_irq_vector,
  input wire logic [1:0] o_irq_level,
  input wire logic i_irq_ack,
  input wire logic o_event_irq
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  wire logic set_ev = i_enable_interrupts_instr | i_interrupt_return_instr | i_avs_write;
  // Bus timing and read width
  wait_one_a: assert property ($rose(i_avs_read | i_avs_write) |-> o_avs_waitrequest ##1 !o_avs_waitrequest) else $error("wait not one cycle");
  two_cycle_a: assert property ((i_avs_read | i_avs_write) && !o_avs_waitrequest ##1 (i_avs_read | i_avs_write) |-> o_avs_waitrequest) else $error("access under two cycles");
  read_upper_a: assert property (o_avs_readdata[31:8] == 24'h0) else $error("upper read bits set");
  // Handoff
  reset_vals_a: assert property ($rose(i_reset_n) |-> !o_irq_req && o_irq_vector == NO_VECTOR && o_irq_level == 2'h0) else $error("bad reset handoff");
  req_level_a: assert property (o_irq_req |-> o_irq_level != 2'h0) else $error("disabled level forwarded");
  req_vector_a: assert property (o_irq_req |-> o_irq_vector < 5'h18) else $error("vector out of range");
  ack_drop_a: assert property (o_irq_req && i_irq_ack |=> !o_irq_req ##1 (!o_irq_req || $past(set_ev, 2))) else $error("request kept after ack");
  di_block_a: assert property (i_disable_interrupts_instr && !set_ev |-> ##2 !o_irq_req) else $error("request while disabled");
  ack_c: cover property (o_irq_req && i_irq_ack);
  di_c: cover property (i_disable_interrupts_instr && o_irq_req);
  event_c: cover property (o_event_irq);
endmodule
bind irpe_top irpe_monitor irpe_monitor_i (.i_clk, .i_reset_n, .i_avs_read, .i_avs_write, .o_avs_readdata,
  .o_avs_waitrequest, .i_enable_interrupts_instr, .i_interrupt_return_instr, .i_disable_interrupts_instr,
  .o_irq_req, .o_irq_vector, .o_irq_level, .i_irq_ack, .o_event_irq);

/* File: irpe_top_tb.sv */
/*
 Self-checking bench for the interrupt unit with a core model.
 Assumes read data stands at the rising edge where waitrequest is sampled low.
*/
`timescale 1ns/100ps
module irpe_top_tb;
  import irpe_pkg::*;
  logic clk, rst_n, rd, wr, ack, ei, interrupt_return_instr, di, low_voltage_detector, en, evt, req, wreq, p7, p6, cmp;
  logic [11:0] addr;
  logic [31:0] wd, rdata;
  logic [7:0] g0, q, rnd;
  logic [5:0] pa;
  logic [3:0] pc;
  logic [4:0] vec, avec;
  logic [1:0] lvl, dly;
  int seed, n_mismatch, tests_run;
  logic [11:0] ridx [7] = '{12'hFC1, 12'hFC2, 12'hFC4, 12'hFC5, 12'hFC6, 12'hFC7, 12'hFC8};
  logic [7:0] rmsk [7] = '{8'h79, 8'h79, 8'hFF, 8'hFF, 8'h0F, 8'h0F, 8'h0F};
  irpe_top irpe_top_i (.i_clk(clk), .i_reset_n(rst_n), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wd), .i_avs_byteenable(4'hF), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
    .i_group0_src(g0), .i_port_a_src(pa), .i_pin7_src(p7), .i_low_voltage_detector(low_voltage_detector), .i_pin6_src(p6),
    .i_comparator(cmp), .i_port_c_src(pc), .i_enable_interrupts_instr(ei), .i_interrupt_return_instr(interrupt_return_instr),
    .i_disable_interrupts_instr(di), .o_irq_req(req), .o_irq_vector(vec), .o_irq_level(lvl), .i_irq_ack(ack),
    .o_event_irq(evt));
  irpe_core_model irpe_core_model_i (.i_clk(clk), .i_reset_n(rst_n), .i_allow(en), .i_delay(dly),
    .i_irq_req(req), .i_irq_vector(vec), .o_irq_ack(ack), .o_taken_vector(avec));
  // Free-running clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic give_verdict();
    $display("Mismatches %0d, checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // A used-up bound ends the run through the verdict
  task automatic bound(input int n);
    if (n >= 20)
    begin
      n_mismatch++;
      give_verdict();
    end
  endtask
  // Hold the request until the rising edge where waitrequest is low; read data is taken there
  task automatic bus(input logic [11:0] a, input logic w, input logic [7:0] d);
    int n = 0;
    @(posedge clk);
    addr <= a;
    wr <= w;
    rd <= !w;
    wd <= {24'h0, d};
    do
    begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    q = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
    bound(n);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    bus(a, 1'b0, 8'h00);
    chk(q, e);
  endtask
  function automatic logic [1:0] lv(input logic [7:0] h, input logic [7:0] l, input int b);
    return {h[b], l[b]};
  endfunction
  // Wait for the shown vector, then let the core take it after a random delay
  task automatic serve(input logic [4:0] v, input logic [1:0] l);
    int n = 0;
    while (req !== 1'b1 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    bound(n);
    chk(vec, v);
    chk(lvl, l);
    @(posedge clk);
    en <= 1'b1;
    dly <= 2'($random(seed));
    n = 0;
    while (req !== 1'b0 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    bound(n);
    @(posedge clk);
    en <= 1'b0;
    chk(avec, v);
  endtask
  task automatic pulse(input int k);
    @(posedge clk);
    {ei, interrupt_return_instr, di} <= 3'h4 >> k;
    @(posedge clk);
    {ei, interrupt_return_instr, di} <= 3'h0;
  endtask
  initial
  begin
    #400000;
    n_mismatch++;
    give_verdict();
  end
  // Main sequence
  initial
  begin
    seed = 32'h4255;
    {rst_n, rd, wr, ei, interrupt_return_instr, di, low_voltage_detector, en, addr, wd, g0, pa, pc, dly, p7, p6, cmp} = '0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 7; i++)
    begin
      rchk(ridx[i], RESET_BYTE);
      rnd = 8'($random(seed)) & rmsk[i];
      bus(ridx[i], 1'b1, rnd);
      rchk(ridx[i], rnd);
      bus(ridx[i], 1'b1, 8'h00);
    end
    bus(12'hFC9, 1'b1, 8'hFF);
    rchk(12'hFC9, 8'h00);
    @(posedge clk);
    pc <= 4'h4;
    g0 <= 8'h40;
    @(posedge clk);
    {pc, g0} <= '0;
    rchk(IDX_PORT_C_REQUEST, 8'h04);
    rchk(IDX_GROUP0_REQUEST, 8'h40);
    chk(req, 1'b0);
    bus(IDX_PORT_C_ENABLE_HIGH, 1'b1, 8'h04);
    bus(IDX_IRQ_CONTROL, 1'b1, 8'h80);
    serve(5'h12, lv(8'h04, 8'h00, 2));
    rchk(IDX_PORT_C_REQUEST, 8'h00);
    rchk(IDX_IRQ_CONTROL, 8'h00);
    bus(IDX_PORT_C_ENABLE_HIGH, 1'b1, 8'h08);
    bus(IDX_PORT_C_ENABLE_LOW, 1'b1, 8'h09);
    bus(IDX_PORT_A_ENABLE_HIGH, 1'b1, 8'h20);
    bus(IDX_PORT_A_ENABLE_LOW, 1'b1, 8'h20);
    bus(IDX_PORT_C_REQUEST, 1'b1, 8'h09);
    bus(IDX_PORT_A_REQUEST, 1'b1, 8'h20);
    pulse(0);
    serve(5'h0D, lv(8'h20, 8'h20, 5));
    pulse(1);
    serve(5'h13, lv(8'h08, 8'h09, 3));
    pulse(0);
    serve(5'h10, lv(8'h08, 8'h09, 0));
    bus(IDX_PORT_C_REQUEST, 1'b1, 8'h01);
    bus(IDX_IRQ_CONTROL, 1'b1, 8'h80);
    pulse(2);
    repeat (2) @(negedge clk);
    chk(req, 1'b0);
    rchk(IDX_IRQ_CONTROL, 8'h00);
    bus(IDX_SHARED_SOURCE_SELECT, 1'b1, 8'h80);
    @(posedge clk);
    low_voltage_detector <= 1'b1;
    cmp <= 1'b1;
    pa <= 6'h01;
    @(posedge clk);
    {low_voltage_detector, cmp, pa} <= '0;
    rchk(IDX_PORT_A_REQUEST, 8'h81);
    bus(IDX_PORT_A_REQUEST, 1'b1, 8'h00);
    bus(IDX_SHARED_SOURCE_SELECT, 1'b1, 8'h40);
    @(posedge clk);
    {p7, p6} <= 2'h3;
    low_voltage_detector <= 1'b1;
    @(posedge clk);
    {p7, p6, low_voltage_detector} <= '0;
    rchk(IDX_PORT_A_REQUEST, 8'h80);
    chk(evt, 1'b0);
    bus(IDX_EVENT_MASK, 1'b1, MASK_EVENT);
    @(negedge clk);
    chk(evt, 1'b1);
    rchk(IDX_EVENT_STATUS, MASK_EVENT);
    @(negedge clk);
    chk(evt, 1'b0);
    give_verdict();
  end
endmodule
